// ==== bench/gauge_driver_serial_link_bench.sv ====
// Bench for the gauge serial link.
// Frames come from gauge_host; self-test inputs are held.
`timescale 1ns/100ps
`default_nettype none
module gauge_driver_serial_link_bench;
    logic clk = 0, rst = 1, self_test_busy = 0, load_fault_one = 1, load_fault_two = 0;
    logic test_mode = 0;
    wire logic sclk, select_n, serial_in, serial_out, fault_out_oe;
    wire logic [8:0] gauge_one_angle, gauge_two_angle, gauge_three_angle;
    logic [31:0] r;
    int num_errors = 0, samples_checked = 0;
    gauge_host host (.*);
    gauge_driver_serial_link uut (.*, .serial_out_oe(), .fault_out_n(),
        .gauge_one_quadrant(), .gauge_one_track(), .gauge_one_load(), .gauge_two_quadrant(),
        .gauge_two_track(), .gauge_two_load(), .gauge_three_load(), .chip_reset_pulse(),
        .oscillator_trim_pulse(), .factory_check_slots(), .factory_check_load());
    always #10 clk = ~clk;
    task chk(input logic [15:0] g, e);
        samples_checked++;
        if (g !== e)
        begin
            num_errors++;
            $display("FAIL %0t got %h exp %h", $time, g, e);
        end
    endtask : chk
    task test_done;
        $display("errors %0d checks %0d", num_errors, samples_checked);
        if (num_errors == 0 && samples_checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : test_done
    initial
    begin
        #1000000 num_errors++;
        test_done;
    end
    initial
    begin
        repeat (5) @(posedge clk);
        #2 rst = 0;
        #2000 host.frame(32'h4003, 16, r);
        chk({1'b0, r[15:1]}, 16'h0001);
        chk(16'(gauge_one_angle), 16'h0001);
        #256000;
        host.frame(32'h2023, 16, r);
        chk(16'(gauge_one_angle), 16'h0001);
        chk(16'(fault_out_oe), 16'h0001);
        #256000;
        host.frame(32'h2022, 16, r);
        chk(16'(r[3]), 16'h0001);
        chk(16'(gauge_one_angle), 16'h0002);
        chk(16'(fault_out_oe), 16'h0000);
        host.frame(32'h4008_4007, 32, r);
        chk(r[31:16], 16'h4007);
        chk(16'(gauge_three_angle), 16'h0001);
        chk(16'(gauge_two_angle), 16'h0000);
        foreach (r[i])
            if (i < 5)
                host.frame(32'h0E040C0A >> (8 * i) & 32'hFF, 16, r);
        test_done;
    end
endmodule : gauge_driver_serial_link_bench
`default_nettype wire

// ==== bench/gauge_host.sv ====
// Host model: sends framed words, captures the reply.
// Serial clock runs only inside frames.
`timescale 1ns/100ps
`default_nettype none
module gauge_host
(
    // Serial pins
    output logic sclk, select_n, serial_in,
    input wire logic serial_out
);
    initial {sclk, select_n, serial_in} = 3'b010;
    task automatic frame(input logic [31:0] w, input int n, output logic [31:0] r);
        select_n = 0;
        for (int i = 0; i < n; i++)
        begin
            #10 serial_in = w[i];
            #30 sclk = 1;
            #40 r[i] = serial_out;
            sclk = 0;
        end
        #40 select_n = 1;
        serial_in = ~serial_in;
        #4000;
    endtask : frame
endmodule : gauge_host
`default_nettype wire

// ==== bench/link_check_sva.sv ====
// Port checker for the gauge serial link.
// Bound to every instance; sees only its ports.
`timescale 1ns/100ps
`default_nettype none
module link_check
(
    // Watched ports
    input wire logic clk, rst, select_n, serial_out_oe, fault_out_n, fault_out_oe,
    input wire logic test_mode, factory_check_load, gauge_one_load, gauge_three_load,
    input wire logic chip_reset_pulse
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    AST_QUIET: assert property (select_n && $past(select_n) |-> !serial_out_oe)
        else $error("out on");
    AST_DRIVE: assert property ((!select_n) [*3] |-> serial_out_oe)
        else $error("out off");
    AST_TEST: assert property (!test_mode |-> !factory_check_load)
        else $error("test write");
    AST_OPEN: assert property (fault_out_oe |-> !fault_out_n)
        else $error("fault level");
    AST_FLT: assert property ($changed(fault_out_oe) |-> $past(select_n))
        else $error("fault moved");
    AST_COMMIT: assert property (gauge_one_load |-> select_n)
        else $error("early load");
    AST_ONE: assert property ($onehot0({gauge_one_load, gauge_three_load, chip_reset_pulse}))
        else $error("two loads");
    AST_RST: assert property (chip_reset_pulse |-> select_n)
        else $error("early reset");
    cover property ($rose(fault_out_oe));
    cover property (gauge_three_load);
    cover property (chip_reset_pulse);
endmodule : link_check
bind gauge_driver_serial_link link_check chk (.*);
`default_nettype wire

// ==== hw/gauge_driver_serial_link.sv ====
// Serial slave port of a three-channel gauge driver: shifting, status out,
// daisy-chain pass-through, decode and commit on select release.
// Assumes a 50 MHz clk, a host-driven serial clock on its own port, and
// self-test results arriving from logic on clk.
//
// Operation
// RL1: Sixteen-bit words, least significant bit first.
// RL2: Select high: ignore clock, data; output off.
// RL3: Sample input on falling serial clock edges.
// RL4: Change output on rising edges; drive only selected.
// RL5: Host holds serial clock low at select edges.
// RL6: Host raises select between sixteen-bit words.
// RL7: Host gives exactly sixteen clocks per word.
// RL8: Select rise commits word to addressed register.
// RL9: Host keeps select high long enough.
// RL10: First rising edge loads status into output.
// RL11: Extra clocks pass earlier input bits out.
// RL12: Address field selects gauge, reset, calibration, test.
// RL13: Test writes ignored while test input low.
// RL14: Commit only when no tracking error found.
// RL15: Fault output asserted within two microseconds.
// RL16: Fault released next select rise or reset.
// RL17: Gauge word field layout with reversed angle.
// RL18: Track enable bit switches continuity checking.
// RL19: Gauge registers cannot be read back.
// RL20: Longer frames commit only last sixteen bits.
// RL21: Discontinuous quadrant rejected and flagged.
// RL22: Status word: tracking, load faults, zeros.
// RL23: Host spaces same-gauge writes by 256 us.
`timescale 1ns/100ps
`default_nettype none

module gauge_driver_serial_link
(
    // System clock and reset
    input  wire logic       clk,
    input  wire logic       rst,
    // Serial link pins
    input  wire logic       sclk,
    input  wire logic       select_n,
    input  wire logic       serial_in,
    output logic            serial_out,
    output logic            serial_out_oe,
    // Fault pin, open drain
    output logic            fault_out_n,
    output logic            fault_out_oe,
    // Self-test results and test pin
    input  wire logic       self_test_busy,
    input  wire logic       load_fault_one,
    input  wire logic       load_fault_two,
    input  wire logic       test_mode,
    // Gauge one
    output logic [8:0]      gauge_one_angle,
    output logic [1:0]      gauge_one_quadrant,
    output logic            gauge_one_track,
    output logic            gauge_one_load,
    // Gauge two
    output logic [8:0]      gauge_two_angle,
    output logic [1:0]      gauge_two_quadrant,
    output logic            gauge_two_track,
    output logic            gauge_two_load,
    // Gauge three
    output logic [8:0]      gauge_three_angle,
    output logic            gauge_three_load,
    // Chip-level requests
    output logic            chip_reset_pulse,
    output logic            oscillator_trim_pulse,
    output logic [15:0]     factory_check_slots,
    output logic            factory_check_load
);

    // Link domain state, clocked by sclk
    logic [15:0]                   rx_shift_reg;
    logic [15:0]                   tx_shift_reg;
    logic [4:0]                    edge_count_reg;
    logic                          link_clear;
    // System domain state
    gauge_link_pkg::commit_state_t state_reg;
    logic [15:0]                   status_reg;
    logic [15:0]                   word_reg;
    logic [1:0]                    pin_sync;
    logic                          selected_sync;
    logic                          selected_prev_reg;
    logic                          test_sync;
    logic                          tracking_fault_reg;
    logic                          word_error_reg;
    logic                          select_rise;
    logic                          commit_ok;
    logic [2:0]                    word_addr;
    logic [1:0]                    word_quadrant;
    logic                          word_track;

    // The angle arrives reversed: its least significant bit sits highest
    function automatic logic [8:0] angle_field(input logic [15:0] word);
        logic [8:0] angle;
        angle = gauge_link_pkg::ANGLE_RESET;
        for (int k = 0; k < gauge_link_pkg::ANGLE_BITS; k++)
        begin
            angle[k] = word[gauge_link_pkg::ANGLE_LSB_POS - k]; // RL17
        end
        return angle;
    endfunction : angle_field

    // Same or neighbouring quadrant is continuous, wrapping after four
    function automatic logic quadrant_continuous(input logic [1:0] prev_quad,
                                                 input logic [1:0] next_quad);
        logic [1:0] step;
        step = next_quad - prev_quad;
        return step != 2'h2; // RL21
    endfunction : quadrant_continuous

    // Select is carried active high so the reset value equals its idle level
    level_sync
    #(
        .WIDTH (2)
    )
    pin_sync_inst
    (
        .clk      (clk),
        .rst      (rst),
        .async_in ({test_mode, ~select_n}),
        .sync_out (pin_sync)
    );

    assign selected_sync = pin_sync[0];
    assign test_sync     = pin_sync[1];
    assign select_rise   = selected_prev_reg && !selected_sync; // RL8
    assign link_clear    = rst || select_n; // RL2
    assign word_addr     = word_reg[gauge_link_pkg::ADDR_MSB:gauge_link_pkg::ADDR_LSB];
    assign word_track    = word_reg[gauge_link_pkg::TRACK_POS];
    assign word_quadrant = {word_reg[gauge_link_pkg::QUAD_HI], word_reg[gauge_link_pkg::QUAD_LO]};
    assign commit_ok     = (state_reg == gauge_link_pkg::ST_APPLY) && !word_error_reg; // RL14

    // Newest bit enters at the top, so bit zero ends at the bottom after
    // sixteen edges and longer frames keep only their last sixteen bits
    always_ff @(negedge sclk or posedge rst)
    begin
        if (rst)
            rx_shift_reg <= gauge_link_pkg::WORD_RESET;
        else if (!select_n) // RL2
            rx_shift_reg <= {serial_in, rx_shift_reg[15:1]}; // RL1 RL3 RL20
    end

    always_ff @(posedge sclk or posedge link_clear)
    begin
        if (link_clear)
            edge_count_reg <= 5'h00;
        else if (edge_count_reg != 5'(gauge_link_pkg::WORD_BITS))
            edge_count_reg <= edge_count_reg + 5'h01;
    end

    // Status tracking bit only moves after select rises; its load bits follow their inputs every clk
    always_ff @(posedge sclk or posedge link_clear)
    begin
        if (link_clear)
            tx_shift_reg <= gauge_link_pkg::WORD_RESET;
        else if (edge_count_reg == 5'h00)
            tx_shift_reg <= {1'b0, status_reg[15:1]}; // RL10
        else
            tx_shift_reg <= {1'b0, tx_shift_reg[15:1]}; // RL1
    end

    // Status first, then input delayed sixteen edges; gauges have no path out
    always_ff @(posedge sclk or posedge link_clear)
    begin
        if (link_clear)
            serial_out <= 1'b0;
        else if (edge_count_reg == 5'h00)
            serial_out <= status_reg[0]; // RL10 RL19
        else if (edge_count_reg == 5'(gauge_link_pkg::WORD_BITS))
            serial_out <= rx_shift_reg[0]; // RL11
        else
            serial_out <= tx_shift_reg[0]; // RL4
    end

    // Output enable drops at once when select rises
    always_ff @(posedge clk or posedge link_clear)
    begin
        if (link_clear)
            serial_out_oe <= 1'b0;
        else
            serial_out_oe <= 1'b1; // RL2 RL4
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            selected_prev_reg <= 1'b0;
        else
            selected_prev_reg <= selected_sync;
    end

    // Capture, check, then apply one word per select rise
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            state_reg <= gauge_link_pkg::ST_IDLE;
        end
        else
        begin
            case (state_reg)
                gauge_link_pkg::ST_IDLE:
                    if (select_rise)
                        state_reg <= gauge_link_pkg::ST_CHECK;
                gauge_link_pkg::ST_CHECK:
                    state_reg <= gauge_link_pkg::ST_APPLY;
                gauge_link_pkg::ST_APPLY:
                    state_reg <= gauge_link_pkg::ST_IDLE;
                default:
                    state_reg <= gauge_link_pkg::ST_IDLE;
            endcase
        end
    end

    // The link is idle once select is high, so the shift register is steady
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            word_reg <= gauge_link_pkg::WORD_RESET;
        else if (state_reg == gauge_link_pkg::ST_IDLE && select_rise)
            word_reg <= rx_shift_reg; // RL8 RL20
    end

    // Continuity is checked only when the word asks for it
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            word_error_reg <= 1'b0;
        end
        else if (state_reg == gauge_link_pkg::ST_CHECK)
        begin
            if (!word_track) // RL18
                word_error_reg <= 1'b0;
            else if (word_addr == gauge_link_pkg::GAUGE_ONE_ANGLE) // RL21
                word_error_reg <= !quadrant_continuous(gauge_one_quadrant, word_quadrant);
            else if (word_addr == gauge_link_pkg::GAUGE_TWO_ANGLE) // RL21
                word_error_reg <= !quadrant_continuous(gauge_two_quadrant, word_quadrant);
            else
                word_error_reg <= 1'b0;
        end
    end

    // Gauge one command
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            gauge_one_angle    <= gauge_link_pkg::ANGLE_RESET;
            gauge_one_quadrant <= gauge_link_pkg::QUAD_RESET;
            gauge_one_track    <= 1'b0;
            gauge_one_load     <= 1'b0;
        end
        else
        begin
            gauge_one_load <= 1'b0;
            if (commit_ok && word_addr == gauge_link_pkg::GAUGE_ONE_ANGLE) // RL12 RL14
            begin
                gauge_one_angle    <= angle_field(word_reg); // RL17
                gauge_one_quadrant <= word_quadrant;
                gauge_one_track    <= word_track; // RL18
                gauge_one_load     <= 1'b1;
            end
        end
    end

    // Gauge two command
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            gauge_two_angle    <= gauge_link_pkg::ANGLE_RESET;
            gauge_two_quadrant <= gauge_link_pkg::QUAD_RESET;
            gauge_two_track    <= 1'b0;
            gauge_two_load     <= 1'b0;
        end
        else
        begin
            gauge_two_load <= 1'b0;
            if (commit_ok && word_addr == gauge_link_pkg::GAUGE_TWO_ANGLE) // RL12 RL14
            begin
                gauge_two_angle    <= angle_field(word_reg);
                gauge_two_quadrant <= word_quadrant;
                gauge_two_track    <= word_track; // RL18
                gauge_two_load     <= 1'b1;
            end
        end
    end

    // Gauge three command, no quadrant
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            gauge_three_angle <= gauge_link_pkg::ANGLE_RESET;
            gauge_three_load  <= 1'b0;
        end
        else
        begin
            gauge_three_load <= 1'b0;
            if (commit_ok && word_addr == gauge_link_pkg::GAUGE_THREE_ANGLE) // RL12
            begin
                gauge_three_angle <= angle_field(word_reg);
                gauge_three_load  <= 1'b1;
            end
        end
    end

    // One-cycle requests; test slots take words only while the test pin is high
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            chip_reset_pulse      <= 1'b0;
            oscillator_trim_pulse <= 1'b0;
            factory_check_slots   <= gauge_link_pkg::WORD_RESET;
            factory_check_load    <= 1'b0;
        end
        else
        begin
            chip_reset_pulse      <= commit_ok
                                     && (word_addr == gauge_link_pkg::CHIP_RESET_REQUEST); // RL12
            oscillator_trim_pulse <= commit_ok
                                     && (word_addr == gauge_link_pkg::OSCILLATOR_TRIM_REQUEST);
            factory_check_load    <= 1'b0;
            if (commit_ok && test_sync && (word_addr == gauge_link_pkg::FACTORY_CHECK_A
                || word_addr == gauge_link_pkg::FACTORY_CHECK_B
                || word_addr == gauge_link_pkg::FACTORY_CHECK_C)) // RL12 RL13
            begin
                factory_check_slots <= word_reg;
                factory_check_load  <= 1'b1;
            end
        end
    end

    // Every applied word replaces the fault, so a clean word or reset clears it
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            tracking_fault_reg <= 1'b0;
        else if (state_reg == gauge_link_pkg::ST_APPLY)
            tracking_fault_reg <= word_error_reg; // RL16 RL21
    end

    // Fault pin follows the tracking fault or a running self-test; status
    // carries the fault and the load results
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            fault_out_oe <= 1'b0;
            fault_out_n  <= 1'b1;
            status_reg   <= gauge_link_pkg::WORD_RESET;
        end
        else
        begin
            fault_out_oe <= tracking_fault_reg || self_test_busy; // RL15 RL16
            fault_out_n  <= !(tracking_fault_reg || self_test_busy);
            status_reg   <= gauge_link_pkg::WORD_RESET;
            status_reg[gauge_link_pkg::STAT_TRACK_POS] <= tracking_fault_reg; // RL22
            status_reg[gauge_link_pkg::STAT_LOAD2_POS] <= load_fault_two;
            status_reg[gauge_link_pkg::STAT_LOAD1_POS] <= load_fault_one;
        end
    end

endmodule : gauge_driver_serial_link

`default_nettype wire

// ==== hw/gauge_link_pkg.sv ====
// Constants used by the gauge driver serial link.
// Assumes a 50 MHz system clock; the link clock is the host's serial clock.
package gauge_link_pkg;

    // Word format
    localparam int WORD_BITS = 16;
    localparam int ADDR_LSB  = 1;
    localparam int ADDR_MSB  = 3;
    localparam int TRACK_POS = 0;
    localparam int QUAD_HI   = 5;
    localparam int QUAD_LO   = 4;
    localparam int ANGLE_MSB_POS = 6;
    localparam int ANGLE_LSB_POS = 14;
    localparam int ANGLE_BITS    = 9;
    localparam int QUAD_BITS     = 2;

    // Register offsets (address field values)
    localparam logic [2:0] GAUGE_ONE_ANGLE         = 3'h1;
    localparam logic [2:0] GAUGE_TWO_ANGLE         = 3'h3;
    localparam logic [2:0] GAUGE_THREE_ANGLE       = 3'h4;
    localparam logic [2:0] CHIP_RESET_REQUEST      = 3'h5;
    localparam logic [2:0] OSCILLATOR_TRIM_REQUEST = 3'h6;
    localparam logic [2:0] FACTORY_CHECK_A         = 3'h0;
    localparam logic [2:0] FACTORY_CHECK_B         = 3'h2;
    localparam logic [2:0] FACTORY_CHECK_C         = 3'h7;

    // Status word bit positions
    localparam int STAT_TRACK_POS = 3;
    localparam int STAT_LOAD2_POS = 2;
    localparam int STAT_LOAD1_POS = 1;

    // Reset values
    localparam logic [8:0]  ANGLE_RESET  = 9'h000;
    localparam logic [1:0]  QUAD_RESET   = 2'h0;
    localparam logic [15:0] WORD_RESET   = 16'h0000;

    // Timing
    localparam int CLK_PERIOD_NS   = 20;
    localparam int FAULT_LIMIT_NS  = 2000;
    localparam int FAULT_LIMIT_CYC = FAULT_LIMIT_NS / CLK_PERIOD_NS;
    localparam int SYNC_STAGES     = 2;

    typedef enum logic [2:0]
    {
        ST_IDLE  = 3'b001,
        ST_CHECK = 3'b010,
        ST_APPLY = 3'b100
    } commit_state_t;

endpackage : gauge_link_pkg

// ==== hw/level_sync.sv ====
// Two-flop synchroniser for slow levels arriving from another domain.
// Assumes each bit is independent; multi-bit words need their own crossing.
`timescale 1ns/100ps
`default_nettype none

module level_sync
#(
    parameter int WIDTH = 1
)
(
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             rst,
    // Levels
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] stage_reg;

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            stage_reg <= '0;
            sync_out  <= '0;
        end
        else
        begin
            stage_reg <= async_in;
            sync_out  <= stage_reg;
        end
    end

endmodule : level_sync

`default_nettype wire
